// [dv/charger_control_state_machine_tb_top.sv]
// Self-checking bench for the charger control block
`timescale 1ns/1ps
module charger_control_state_machine_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, thm_low = 0, err, stat_oe_n;
  logic [7:0] paddr = 8'h00;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr;
  logic [1:0] ilim;
  logic [2:0] ty [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
  logic [1:0] lim [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
  charger_pkg::sense_type req = '0, sense_in;
  charger_pkg::power_ctrl_type pc;
  charger_pkg::charge_state_type st;
  int failures = 0, n_checks = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  charger_partner u_partner (.pclk(pclk), .req(req), .thm_pull_low(thm_low), .sense_in(sense_in));
  charger_control_state_machine #(.PREQUAL_TICKS(32'h5), .TOPOFF_TICKS(32'hA), .TERM_TICKS(32'h5),
    .OCP_RETRY_TICKS(32'h5), .BOOST_OFF_TICKS(32'h5)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr), .sense_in(sense_in), .power_ctrl(pc), .input_current_limit(ilim), .stat_out(),
    .stat_oe_n(stat_oe_n), .input_good_out(), .input_good_oe_n(), .charge_state(st));
  // -------------------------------------
  // Tasks
  // -------------------------------------
  task automatic test_done();
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_st(input charger_pkg::charge_state_type s);
    int n;
    n = 0;
    while (st !== s && n < 4000) begin @(posedge pclk); n++; end
    // Outputs follow the state one edge later
    @(posedge pclk);
    chk({28'h0, st}, {28'h0, s});
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin failures++; test_done(); end
  end
  // -------------------------------------
  // Main sequence
  // -------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(ilim, charger_pkg::ILIM_500MA);
    apb(1'b0, charger_pkg::CTRL_ADDR, 32'h0);
    chk(rd, {30'h0, charger_pkg::CTRL_RESET});
    pstrb <= 4'hE;
    apb(1'b1, charger_pkg::CTRL_ADDR, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, charger_pkg::CTRL_ADDR, 32'h0);
    chk(rd, {30'h0, charger_pkg::CTRL_RESET});
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    req.input_valid <= 1'b1; req.detect_done <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      req.detected_adapter_type <= ty[i];
      repeat (6) @(posedge pclk);
      chk(ilim, lim[i]);
    end
    req.vbat_above_prechg <= 1'b1; req.vbat_above_trickle <= 1'b1;
    req.vbat_above_reg <= 1'b1; req.current_below_topoff <= 1'b1;
    wait_st(charger_pkg::ST_TOPOFF);
    wait_st(charger_pkg::ST_DONE);
    chk(pc.charge_enable, 1'b0);
    req.vbat_below_restart <= 1'b1; req.vbat_above_reg <= 1'b0;
    wait_st(charger_pkg::ST_FAST_CC);
    req.vbat_below_restart <= 1'b0; req.below_cool <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(pc.current_half, 1'b1);
    apb(1'b1, charger_pkg::CTRL_ADDR, 32'h0);
    repeat (6) @(posedge pclk);
    chk(pc.current_half, 1'b0);
    apb(1'b1, charger_pkg::CTRL_ADDR, 32'h1);
    req.below_cool <= 1'b0; req.above_warm <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(pc.vreg_reduce, 1'b1);
    req.above_warm <= 1'b0; req.below_cold <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(pc.charge_enable, 1'b0);
    req.below_cold <= 1'b0; thm_low <= 1'b1;
    wait_st(charger_pkg::ST_BUCK);
    chk(pc.charge_enable, 1'b0);
    thm_low <= 1'b0;
    wait_st(charger_pkg::ST_FAST_CC);
    chk(pc.charge_enable, 1'b1);
    req.tj_over_shutdown <= 1'b1;
    wait_st(charger_pkg::ST_THERMAL_SHUTDOWN);
    chk(pc.charge_enable, 1'b0);
    req.tj_over_shutdown <= 1'b0; req.vbat_above_prechg <= 1'b0;
    wait_st(charger_pkg::ST_TIMER_FAULT);
    chk(stat_oe_n, 1'b1);
    req.vbat_above_prechg <= 1'b1;
    repeat (20) @(posedge pclk);
    chk({28'h0, st}, {28'h0, charger_pkg::ST_TIMER_FAULT});
    req.input_valid <= 1'b0;
    wait_st(charger_pkg::ST_INIT);
    req.charger_input_below_boost <= 1'b1; req.boost_enable_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(pc.boost_enable, 1'b1);
    chk({pc.bypass_switch_closed, pc.cc_rd_connect, pc.cc_low_power}, 3'h5);
    req.boost_overload <= 1'b1; req.cc2_rd <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(pc.bypass_switch_closed, 1'b0);
    chk({pc.cc_low_power, pc.cc1_source, pc.cc2_source}, 3'h1);
    repeat (700) @(posedge pclk);
    chk(pc.bypass_switch_closed, 1'b0);
    repeat (600) @(posedge pclk);
    chk(pc.bypass_switch_closed, 1'b1);
    // Discharge overcurrent trips after its delay, retries once the system node stays low
    req.batt_overcurrent <= 1'b1;
    repeat (19800) @(posedge pclk);
    chk(pc.battery_path_closed, 1'b1);
    repeat (600) @(posedge pclk);
    chk(pc.battery_path_closed, 1'b0);
    req.batt_overcurrent <= 1'b0; req.sys_below_restart <= 1'b1;
    repeat (1300) @(posedge pclk);
    chk(pc.battery_path_closed, 1'b1);
    test_done();
  end
endmodule

// [dv/charger_partner.sv]
// Far-side model: adapter, battery sense and host pull on the thermistor pin
`timescale 1ns/1ps
module charger_partner (
  input wire logic pclk, // Bench clock
  input wire charger_pkg::sense_type req, // Requested far-side levels
  input wire logic thm_pull_low, // Host open-drain pull on thermistor pin
  output charger_pkg::sense_type sense_in // Levels seen by the device
);
  // -------------------------------------
  // Pin levels
  // -------------------------------------
  // Input removal and reinsertion come from req.input_valid
  always_ff @(posedge pclk) begin
    sense_in <= req;
    sense_in.thermistor_grounded <= thm_pull_low;
  end
endmodule

// [rtl/charger_control_state_machine.sv]
// Charger control state machine with boost, overcurrent and thermistor logic
// How it works
// - Top-off moves to done after the full top-off time.
// - Done returns to fast-charge CC when battery falls below restart level.
// - No charge current is delivered while in done.
// - Separate dwell limits for prequal, fast-charge CC plus CV, and top-off.
// - Entering timer fault releases the status output to high impedance.
// - Timer fault keeps charger off until the input is removed and reinserted or thermal shutdown trips.
// - Junction over shutdown temperature forces thermal shutdown, charger off.
// - Reverse boost starts only with boost pin high and input below 0.7V, stops when the pin goes low.
// - Boost overload opens the switch and retries after 300ms.
// - Persistent overload cycles the switch about 60ms on, 300ms off.
// - CC pins low-power until Rd seen, then source on active pin only.
// - Discharge overcurrent past its delay opens battery switch, stops buck.
// - After system node low for retry time, restart; repeat until cleared.
// - Grounded thermistor pin disables charging; host drives it open-drain.
// - Thermistor variant halves fast-charge current in the cool zone.
// - Thermistor variant lowers termination voltage 150mV in the warm zone.
// - Charging suspends below cold or above hot thresholds.
// - Hot/cold variant makes no warm or cool adjustment.
// - Boost pin high closes bypass path, drops Rd, connects source current.
// - Input limit 500mA before detection and for SDP, 1.5A for CDP/DCP.
// - Unknown adapter or contact timeout sets the 3A input limit.
// - Invalid input enters init with no charge current, timer at zero.
// - CV enters top-off after current stays below top-off level long enough.
`timescale 1ns/1ps
module charger_control_state_machine #(
  parameter logic [31:0] PREQUAL_TICKS = 32'(charger_pkg::PREQUAL_LIMIT_US / charger_pkg::TICK_TIME_US),
  parameter logic [31:0] FASTCHARGE_TICKS = 32'(charger_pkg::FASTCHARGE_LIMIT_US / charger_pkg::TICK_TIME_US),
  parameter logic [31:0] TOPOFF_TICKS = 32'(charger_pkg::TOPOFF_TIME_US / charger_pkg::TICK_TIME_US),
  parameter logic [31:0] TERM_TICKS = 32'(charger_pkg::TERMINATION_DELAY_US / charger_pkg::TICK_TIME_US),
  parameter logic [31:0] OVERCURRENT_TICKS = 32'(charger_pkg::OVERCURRENT_DELAY_US / charger_pkg::TICK_TIME_US),
  parameter logic [31:0] OCP_RETRY_TICKS = 32'(charger_pkg::OCP_RETRY_US / charger_pkg::TICK_TIME_US),
  parameter logic [31:0] BOOST_OFF_TICKS = 32'(charger_pkg::BOOST_RETRY_OFF_US / charger_pkg::TICK_TIME_US),
  parameter logic [31:0] BOOST_ON_TICKS = 32'(charger_pkg::BOOST_RETRY_ON_US / charger_pkg::TICK_TIME_US)
) (
  input wire logic pclk, // 200 MHz clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire charger_pkg::sense_type sense_in, // Comparator and pin levels, async
  output charger_pkg::power_ctrl_type power_ctrl, // Power stage controls
  output logic [1:0] input_current_limit, // Input limit code
  output logic stat_out, // Status pin level, always low
  output logic stat_oe_n, // Status pin enable, low drives
  output logic input_good_out, // Input good pin level, always low
  output logic input_good_oe_n, // Input good enable, low drives
  output charger_pkg::charge_state_type charge_state // Charge state
);
  // ------------------------------------------------------------
  // Synchronisers and tick
  // ------------------------------------------------------------
  charger_pkg::sense_type sense_meta;
  charger_pkg::sense_type s;
  logic [charger_pkg::TICK_W-1:0] tick_count;
  logic tick;
  logic [1:0] ctrl;
  charger_pkg::boost_state_type boost_state;
  charger_pkg::ocp_state_type ocp_state;
  logic [31:0] dwell_count;
  logic [31:0] term_count;
  logic [31:0] boost_count;
  logic [31:0] ocp_count;

  // Two-stage sync of every external level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_meta <= '0;
      s <= '0;
    end else begin
      sense_meta <= sense_in;
      s <= sense_meta;
    end
  end

  // Microsecond tick divider
  wire tick_wrap = (tick_count == charger_pkg::TICK_W'(charger_pkg::TICK_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_count <= '0;
      tick <= 1'b0;
    end else begin
      tick_count <= tick_wrap ? '0 : tick_count + 8'h01;
      tick <= tick_wrap;
    end
  end

  // ------------------------------------------------------------
  // Charge state machine
  // ------------------------------------------------------------
  charger_pkg::charge_state_type next_charge_state;
  wire jeita = ctrl[charger_pkg::CTRL_JEITA_BIT];
  wire lifepo4 = ctrl[charger_pkg::CTRL_LIFEPO4_BIT];
  wire suspend = s.below_cold | s.above_hot;
  wire ocp_off = (ocp_state == charger_pkg::O_FAULT);
  wire pq_expired = (dwell_count >= PREQUAL_TICKS);
  wire fc_expired = (dwell_count >= FASTCHARGE_TICKS);
  wire to_expired = (dwell_count >= TOPOFF_TICKS);
  wire term_done = (term_count >= TERM_TICKS);

  // Next charge state, thermal shutdown first, then input loss
  always_comb begin
    next_charge_state = charge_state;
    if (s.tj_over_shutdown) begin
      next_charge_state = charger_pkg::ST_THERMAL_SHUTDOWN;
    end else if (charge_state == charger_pkg::ST_THERMAL_SHUTDOWN) begin
      next_charge_state = charger_pkg::ST_INIT;
    end else if (!s.input_valid) begin
      next_charge_state = charger_pkg::ST_INIT;
    end else if (charge_state == charger_pkg::ST_TIMER_FAULT) begin
      next_charge_state = charger_pkg::ST_TIMER_FAULT;
    end else if (s.thermistor_grounded) begin
      next_charge_state = charger_pkg::ST_BUCK;
    end else begin
      case (charge_state)
        charger_pkg::ST_INIT, charger_pkg::ST_BUCK: begin
          if (!s.vbat_above_prechg) next_charge_state = charger_pkg::ST_PRECHARGE;
          else if (!s.vbat_above_trickle && !lifepo4) next_charge_state = charger_pkg::ST_TRICKLE;
          else if (!s.vbat_above_reg) next_charge_state = charger_pkg::ST_FAST_CC;
          else next_charge_state = charger_pkg::ST_FAST_CV;
        end
        charger_pkg::ST_PRECHARGE: begin
          if (pq_expired) next_charge_state = charger_pkg::ST_TIMER_FAULT;
          else if (s.vbat_above_prechg) next_charge_state = lifepo4 ? charger_pkg::ST_FAST_CC : charger_pkg::ST_TRICKLE;
        end
        charger_pkg::ST_TRICKLE: begin
          if (pq_expired) next_charge_state = charger_pkg::ST_TIMER_FAULT;
          else if (s.vbat_above_trickle) next_charge_state = charger_pkg::ST_FAST_CC;
        end
        charger_pkg::ST_FAST_CC: begin
          if (fc_expired) next_charge_state = charger_pkg::ST_TIMER_FAULT;
          else if (s.vbat_above_reg) next_charge_state = charger_pkg::ST_FAST_CV;
        end
        charger_pkg::ST_FAST_CV: begin
          if (fc_expired) next_charge_state = charger_pkg::ST_TIMER_FAULT;
          else if (term_done) next_charge_state = charger_pkg::ST_TOPOFF;
        end
        charger_pkg::ST_TOPOFF: begin
          if (s.vbat_below_restart) next_charge_state = charger_pkg::ST_FAST_CC;
          else if (to_expired) next_charge_state = charger_pkg::ST_DONE;
        end
        charger_pkg::ST_DONE: begin
          if (s.vbat_below_restart) next_charge_state = charger_pkg::ST_FAST_CC;
        end
        default: next_charge_state = charger_pkg::ST_INIT;
      endcase
    end
  end

  // Dwell timer: cleared on state change except CC to CV, held at zero in init, frozen on suspend
  wire cc_to_cv = (charge_state == charger_pkg::ST_FAST_CC) && (next_charge_state == charger_pkg::ST_FAST_CV);
  wire dwell_clear = (charge_state == charger_pkg::ST_INIT) || ((next_charge_state != charge_state) && !cc_to_cv);
  wire dwell_run = tick && !suspend && (dwell_count != 32'hFFFFFFFF);
  wire term_run = (charge_state == charger_pkg::ST_FAST_CV) && s.current_below_topoff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_state <= charger_pkg::ST_INIT;
      dwell_count <= '0;
      term_count <= '0;
    end else begin
      charge_state <= next_charge_state;
      dwell_count <= dwell_clear ? '0 : dwell_count + {31'h0, dwell_run};
      term_count <= !term_run ? '0 : term_count + {31'h0, tick && !term_done};
    end
  end

  // ------------------------------------------------------------
  // Reverse boost with overload retry
  // ------------------------------------------------------------
  charger_pkg::boost_state_type next_boost_state;
  wire boost_off_done = (boost_count >= BOOST_OFF_TICKS);
  wire boost_on_done = (boost_count >= BOOST_ON_TICKS);

  // Retry cadence: off for the retry delay, then a trial on-window
  always_comb begin
    next_boost_state = boost_state;
    if (!s.boost_enable_pin) begin
      next_boost_state = charger_pkg::B_OFF;
    end else begin
      case (boost_state)
        charger_pkg::B_OFF: if (s.charger_input_below_boost) next_boost_state = charger_pkg::B_ON;
        charger_pkg::B_ON: if (s.boost_overload) next_boost_state = charger_pkg::B_WAIT;
        charger_pkg::B_WAIT: if (boost_off_done) next_boost_state = charger_pkg::B_TRY;
        charger_pkg::B_TRY: begin
          if (boost_on_done) next_boost_state = s.boost_overload ? charger_pkg::B_WAIT : charger_pkg::B_ON;
        end
        default: next_boost_state = charger_pkg::B_OFF;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_state <= charger_pkg::B_OFF;
      boost_count <= '0;
    end else begin
      boost_state <= next_boost_state;
      boost_count <= (next_boost_state != boost_state) ? '0 : boost_count + {31'h0, tick};
    end
  end

  // ------------------------------------------------------------
  // Battery discharge overcurrent
  // ------------------------------------------------------------
  charger_pkg::ocp_state_type next_ocp_state;
  always_comb begin
    next_ocp_state = ocp_state;
    case (ocp_state)
      charger_pkg::O_OK: if (s.batt_overcurrent) next_ocp_state = charger_pkg::O_DEBOUNCE;
      charger_pkg::O_DEBOUNCE: begin
        if (!s.batt_overcurrent) next_ocp_state = charger_pkg::O_OK;
        else if (ocp_count >= OVERCURRENT_TICKS) next_ocp_state = charger_pkg::O_FAULT;
      end
      charger_pkg::O_FAULT: if (ocp_count >= OCP_RETRY_TICKS) next_ocp_state = charger_pkg::O_OK;
      default: next_ocp_state = charger_pkg::O_OK;
    endcase
  end

  // Retry count only runs while the system node stays low
  wire ocp_hold = (ocp_state == charger_pkg::O_DEBOUNCE) || s.sys_below_restart;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ocp_state <= charger_pkg::O_OK;
      ocp_count <= '0;
    end else begin
      ocp_state <= next_ocp_state;
      ocp_count <= (next_ocp_state != ocp_state || !ocp_hold) ? '0 : ocp_count + {31'h0, tick};
    end
  end

  // ------------------------------------------------------------
  // Output decode
  // ------------------------------------------------------------
  charger_pkg::power_ctrl_type next_power_ctrl;
  logic [1:0] next_ilim;
  wire charging = (charge_state inside {charger_pkg::ST_PRECHARGE, charger_pkg::ST_TRICKLE,
    charger_pkg::ST_FAST_CC, charger_pkg::ST_FAST_CV, charger_pkg::ST_TOPOFF});
  wire boost_run = (boost_state != charger_pkg::B_OFF);
  wire switch_on = (boost_state == charger_pkg::B_ON) || (boost_state == charger_pkg::B_TRY);
  wire cool_zone = s.below_cool && !s.below_cold;
  wire warm_zone = s.above_warm && !s.above_hot;
  wire buck_ok = s.input_valid && !boost_run && !ocp_off && (charge_state != charger_pkg::ST_THERMAL_SHUTDOWN);
  wire adapter_low = (s.detected_adapter_type == charger_pkg::ADAPTER_SDP);
  wire adapter_mid = (s.detected_adapter_type == charger_pkg::ADAPTER_CDP) ||
    (s.detected_adapter_type == charger_pkg::ADAPTER_DCP);

  // Power stage controls
  always_comb begin
    next_power_ctrl.charge_enable = charging && !suspend && buck_ok;
    next_power_ctrl.current_half = jeita && cool_zone;
    next_power_ctrl.vreg_reduce = jeita && warm_zone;
    next_power_ctrl.buck_enable = buck_ok && (charge_state != charger_pkg::ST_TIMER_FAULT);
    next_power_ctrl.boost_enable = boost_run;
    next_power_ctrl.bypass_switch_closed = switch_on;
    next_power_ctrl.battery_path_closed = !ocp_off;
    next_power_ctrl.cc_rd_connect = !boost_run;
    next_power_ctrl.cc_low_power = boost_run && !s.cc1_rd && !s.cc2_rd;
    next_power_ctrl.cc1_source = boost_run && s.cc1_rd;
    next_power_ctrl.cc2_source = boost_run && s.cc2_rd && !s.cc1_rd;
  end

  // Input current limit from the detected adapter type
  assign next_ilim = !s.detect_done ? charger_pkg::ILIM_500MA :
    adapter_low ? charger_pkg::ILIM_500MA : adapter_mid ? charger_pkg::ILIM_1500MA :
    charger_pkg::ILIM_3000MA;

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_ctrl <= '0;
      input_current_limit <= charger_pkg::ILIM_500MA;
      stat_oe_n <= 1'b1;
      input_good_oe_n <= 1'b1;
      stat_out <= 1'b0;
      input_good_out <= 1'b0;
    end else begin
      power_ctrl <= next_power_ctrl;
      input_current_limit <= next_ilim;
      stat_oe_n <= !charging;
      input_good_oe_n <= !((s.input_valid && buck_ok) || boost_run);
      stat_out <= 1'b0;
      input_good_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  wire access = psel && penable;
  wire hit_ctrl = (paddr == charger_pkg::CTRL_ADDR);
  wire hit_status = (paddr == charger_pkg::STATUS_ADDR);
  wire do_write = access && pready && pwrite && hit_ctrl && pstrb[0];
  wire [31:0] status_word = {14'h0, input_current_limit, ocp_state, boost_state, s.above_hot, s.above_warm,
    s.below_cool, s.below_cold, 4'h0, charge_state};
  wire [31:0] read_mux = hit_ctrl ? {30'h0, ctrl} : hit_status ? status_word : 32'h0;

  // One wait state, then ready with data or error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
      ctrl <= charger_pkg::CTRL_RESET;
    end else begin
      pready <= access && !pready;
      prdata <= (access && !pready && !pwrite) ? read_mux : 32'h0;
      pslverr <= access && !pready && !(hit_ctrl || hit_status);
      if (do_write) ctrl <= pwdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_done_no_current;
    charge_state == charger_pkg::ST_DONE |=> !power_ctrl.charge_enable;
  endproperty
  a_done_no_current: assert property (p_done_no_current) else $error("charge in done");

  property p_fault_stat;
    charge_state == charger_pkg::ST_TIMER_FAULT |=> stat_oe_n && !power_ctrl.buck_enable;
  endproperty
  a_fault_stat: assert property (p_fault_stat) else $error("fault status not released");

  property p_fault_sticky;
    charge_state == charger_pkg::ST_TIMER_FAULT && s.input_valid && !s.tj_over_shutdown
      |=> charge_state == charger_pkg::ST_TIMER_FAULT;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault left with input");

  property p_tsd;
    s.tj_over_shutdown |=> charge_state == charger_pkg::ST_THERMAL_SHUTDOWN ##1 !power_ctrl.charge_enable;
  endproperty
  a_tsd: assert property (p_tsd) else $error("no thermal shutdown");

  property p_init_timer;
    charge_state == charger_pkg::ST_INIT |=> dwell_count == 32'h0;
  endproperty
  a_init_timer: assert property (p_init_timer) else $error("timer not zero in init");

  property p_boost_overload;
    boost_state == charger_pkg::B_ON && s.boost_overload && s.boost_enable_pin
      |=> boost_state == charger_pkg::B_WAIT ##1 !power_ctrl.bypass_switch_closed;
  endproperty
  a_boost_overload: assert property (p_boost_overload) else $error("switch not opened");

  property p_ocp;
    ocp_state == charger_pkg::O_FAULT |=> !power_ctrl.battery_path_closed && !power_ctrl.buck_enable;
  endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent path not opened");

  property p_suspend;
    (s.below_cold || s.above_hot) |=> !power_ctrl.charge_enable;
  endproperty
  a_suspend: assert property (p_suspend) else $error("charging at temperature extreme");

  property p_hotcold_variant;
    !jeita |=> !power_ctrl.current_half && !power_ctrl.vreg_reduce;
  endproperty
  a_hotcold_variant: assert property (p_hotcold_variant) else $error("zone adjust in hot/cold variant");

  property p_ilim_default;
    !s.detect_done |=> input_current_limit == charger_pkg::ILIM_500MA;
  endproperty
  a_ilim_default: assert property (p_ilim_default) else $error("limit not default");

  property p_apb_ready;
    access && !pready |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing");
endmodule

// [rtl/charger_pkg.sv]
// Shared constants and types for the charger control block
package charger_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_TIME_NS = 1000;
  localparam int TICK_CYCLES = TICK_TIME_NS * 1000 / CLK_PERIOD_PS;
  localparam int TICK_W = 8;
  localparam int TICK_TIME_US = 1;
  localparam int TIME_W = 32;
  localparam int BOOST_RETRY_OFF_US = 300000;
  localparam int BOOST_RETRY_ON_US = 60000;
  localparam int PREQUAL_LIMIT_US = 1000000000;
  localparam int FASTCHARGE_LIMIT_US = 2000000000;
  localparam int TOPOFF_TIME_US = 500000000;
  localparam int TERMINATION_DELAY_US = 1000000;
  localparam int OVERCURRENT_DELAY_US = 100;
  localparam int OCP_RETRY_US = 1000000;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam int CTRL_JEITA_BIT = 0;
  localparam int CTRL_LIFEPO4_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // ------------------------------------------------------------
  // Codes
  // ------------------------------------------------------------
  localparam logic [1:0] ILIM_500MA = 2'h0;
  localparam logic [1:0] ILIM_1500MA = 2'h1;
  localparam logic [1:0] ILIM_3000MA = 2'h2;
  localparam logic [2:0] ADAPTER_SDP = 3'h1;
  localparam logic [2:0] ADAPTER_CDP = 3'h2;
  localparam logic [2:0] ADAPTER_DCP = 3'h3;
  typedef enum logic [3:0] {ST_INIT, ST_BUCK, ST_PRECHARGE, ST_TRICKLE, ST_FAST_CC, ST_FAST_CV,
    ST_TOPOFF, ST_DONE, ST_TIMER_FAULT, ST_THERMAL_SHUTDOWN} charge_state_type;
  typedef enum logic [1:0] {B_OFF, B_ON, B_WAIT, B_TRY} boost_state_type;
  typedef enum logic [1:0] {O_OK, O_DEBOUNCE, O_FAULT} ocp_state_type;
  typedef struct packed {
    logic input_valid;
    logic vbat_above_prechg;
    logic vbat_above_trickle;
    logic vbat_above_reg;
    logic vbat_below_restart;
    logic current_below_topoff;
    logic tj_over_shutdown;
    logic thermistor_grounded;
    logic below_cold;
    logic below_cool;
    logic above_warm;
    logic above_hot;
    logic boost_enable_pin;
    logic charger_input_below_boost;
    logic boost_overload;
    logic batt_overcurrent;
    logic sys_below_restart;
    logic cc1_rd;
    logic cc2_rd;
    logic detect_done;
    logic [2:0] detected_adapter_type;
  } sense_type;
  typedef struct packed {
    logic charge_enable;
    logic current_half;
    logic vreg_reduce;
    logic buck_enable;
    logic boost_enable;
    logic bypass_switch_closed;
    logic battery_path_closed;
    logic cc_rd_connect;
    logic cc_low_power;
    logic cc1_source;
    logic cc2_source;
  } power_ctrl_type;
endpackage
